// ===== core/vst_tx_path.sv
// Function
// [RULE1] Capture select picks host or reference clock.
// [RULE2] Buffer used unless full-rate reference capture.
// [RULE3] Host clock drift stays within half period.
// [RULE4] Buffer slip raises error until reinitialised.
// [RULE5] Writing init latch zero recentres buffer.
// [RULE6] Error active sends fixed error character.
// [RULE7] Self-test runs 511-character LFSR pattern.
// [RULE8] Reset turns pattern generator off.
// [RULE9] Self-test ignores parallel data inputs.
// [RULE10] Bit rate is reference times 10/20.
// [RULE11] Character clock driven out on pin.
// [RULE12] Speed band selects rate; one combination reserved.
// [RULE13] Reference frequency within band limits.
// [RULE14] Two drivers enabled independently, off powers down.
// [RULE15] Both drivers off powers down transmitter.
// [RULE16] Reset disables all serial drivers.
// [RULE17] Re-enable needs buffer init, settle time.
// [RULE18] Shifter loads per character, sends LSB first.
`timescale 1ns/100ps
`include "vst_cfg.svh"

module vst_tx_path
  import vst_pkg::*;
#(
  parameter int PAB_DEPTH = 4
) (
  // Clock and synchronous active-low reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address channel.
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response channel.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address channel.
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data channel.
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Parallel host side, all asynchronous to aclk.
  input wire logic [9:0] tx_char_in,
  input wire logic host_tx_clock,
  input wire logic tx_reference_clock,
  // Serial and status outputs.
  output logic tx_serial_out1,
  output logic tx_serial_out2,
  output logic tx_char_clock_out,
  output logic tx_phase_error,
  output logic [9:0] tx_char_word,
  output logic [4:0] tx_bit_mult,
  output logic tx_logic_on,
  output logic irq
);

  localparam int PTR_W = (PAB_DEPTH > 2) ? $clog2(PAB_DEPTH) : 1;
  localparam logic [PTR_W:0] OCC_FULL = (PTR_W + 1)'(PAB_DEPTH);
  localparam logic [PTR_W:0] OCC_HALF = (PTR_W + 1)'(PAB_DEPTH / 2);
  localparam logic [PTR_W-1:0] PTR_HALF = PTR_W'(PAB_DEPTH / 2);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and edge detection.

  logic host_clk_s; // Synchronised host transmit clock.
  logic ref_clk_s; // Synchronised reference clock.
  logic [9:0] char_s; // Synchronised parallel character, same latency as clocks.
  logic host_clk_d_reg; // Previous host clock level for edge finding.
  logic ref_clk_d_reg; // Previous reference clock level for edge finding.

  // Data and clocks pass matched two-stage paths so edges and data stay aligned.
  vst_sync #(.W(12)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({host_tx_clock, tx_reference_clock, tx_char_in}),
    .q({host_clk_s, ref_clk_s, char_s})
  );

  // Edge detectors look only at the second synchroniser stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_clk_d_reg <= 1'b0;
      ref_clk_d_reg <= 1'b0;
    end else begin
      host_clk_d_reg <= host_clk_s;
      ref_clk_d_reg <= ref_clk_s;
    end
  end

  wire host_rise = host_clk_s & ~host_clk_d_reg;
  wire ref_rise = ref_clk_s & ~ref_clk_d_reg;
  wire ref_fall = ~ref_clk_s & ref_clk_d_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration fields.

  logic [7:0] ctrl_reg; // Configuration latches.
  logic [`VST_INT_W-1:0] int_stat_reg; // Sticky event bits.
  logic [`VST_INT_W-1:0] int_en_reg; // Interrupt enables.

  wire cap_sel = ctrl_reg[`VST_CTRL_CAPSEL];
  wire rate_sel = ctrl_reg[`VST_CTRL_RATE];
  wire selftest = ctrl_reg[`VST_CTRL_SELFTEST];
  wire [1:0] drv_en = ctrl_reg[`VST_CTRL_DRV_HI:`VST_CTRL_DRV_LO];
  vst_band_t band;
  assign band = vst_band_t'(ctrl_reg[`VST_CTRL_BAND_HI:`VST_CTRL_BAND_LO]);

  // Half-rate clocking in the low band, and the unused code, are reserved.
  wire cfg_invalid = ((band == VST_BAND_LOW) & rate_sel) | (band == VST_BAND_RSVD); // [RULE12]
  // Transmitter logic runs only while at least one driver is enabled.
  wire logic_on = |drv_en; // [RULE15]
  // The buffer is bypassed only for full-rate reference capture.
  wire buffered = ~cap_sel | rate_sel; // [RULE2]

  //////////////////////////////////////////////////////////////////////////////
  // Character timing and input register.

  // Character tick: every reference rise at full rate, both edges at half rate.
  wire char_tick = logic_on & (ref_rise | (rate_sel & ref_fall)); // [RULE10]
  // Capture edge follows the capture clock select; self-test blocks capture.
  wire ref_cap = rate_sel ? (ref_rise | ref_fall) : ref_rise;
  wire cap_strobe = logic_on & ~selftest & (cap_sel ? ref_cap : host_rise); // [RULE1] [RULE9]

  logic [9:0] in_reg; // Input register.
  logic cap_d_reg; // Capture strobe delayed to the buffer write.

  // Input register samples the synchronised bus on the selected edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_reg <= 10'h000;
      cap_d_reg <= 1'b0;
    end else begin
      cap_d_reg <= cap_strobe;
      if (cap_strobe) begin
        in_reg <= char_s; // [RULE1]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Phase-align buffer.

  logic [9:0] pab_mem [PAB_DEPTH]; // Buffer storage.
  logic [PTR_W-1:0] wr_ptr_reg; // Write pointer.
  logic [PTR_W-1:0] rd_ptr_reg; // Read pointer.
  logic [PTR_W:0] occ_reg; // Entries held.
  logic pab_err_reg; // Phase-align error, held until init.
  logic init_pulse; // Init latch written with zero.

  wire pab_wr = cap_d_reg & buffered & ~pab_err_reg;
  wire pab_rd = char_tick & buffered & ~selftest & ~pab_err_reg;
  // Slip is a write into a full buffer or a read from an empty one.
  wire overflow = pab_wr & ~pab_rd & (occ_reg == OCC_FULL); // [RULE4]
  wire underflow = pab_rd & ~pab_wr & (occ_reg == {(PTR_W + 1){1'b0}}); // [RULE4]
  wire pab_err_set = overflow | underflow;
  wire do_wr = pab_wr & ~overflow;
  wire do_rd = pab_rd & ~underflow;
  // Power-down leaves the buffer state meaningless, so it is recentred too.
  wire pab_flush = init_pulse | ~logic_on;

  // Pointers restart half a buffer apart, capturing the present phase.
  always_ff @(posedge aclk) begin
    if (!aresetn || pab_flush) begin
      wr_ptr_reg <= PTR_HALF; // [RULE5]
      rd_ptr_reg <= {PTR_W{1'b0}};
      occ_reg <= OCC_HALF;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(PAB_DEPTH - 1)) ? {PTR_W{1'b0}} : wr_ptr_reg + PTR_ONE;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(PAB_DEPTH - 1)) ? {PTR_W{1'b0}} : rd_ptr_reg + PTR_ONE;
      end
      if (do_wr && !do_rd) begin
        occ_reg <= occ_reg + (PTR_W + 1)'(1);
      end else if (do_rd && !do_wr) begin
        occ_reg <= occ_reg - (PTR_W + 1)'(1);
      end
    end
  end

  // Storage has no reset; the first half-buffer read after recentring holds old or unwritten entries.
  always_ff @(posedge aclk) begin
    if (do_wr) begin
      pab_mem[wr_ptr_reg] <= in_reg;
    end
  end

  // Error sticks until the buffer is reinitialised; init takes precedence.
  always_ff @(posedge aclk) begin
    if (!aresetn || init_pulse) begin
      pab_err_reg <= 1'b0; // [RULE5]
    end else if (pab_err_set) begin
      pab_err_reg <= 1'b1; // [RULE4]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pattern generator and character source.

  logic [8:0] lfsr_reg; // Nine-bit LFSR, maximal period of 511.
  wire lfsr_step = char_tick & selftest;
  wire [8:0] lfsr_next = {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[`VST_LFSR_TAP]};
  wire pattern_wrap = lfsr_step & (lfsr_next == `VST_LFSR_SEED);
  wire [9:0] pattern_char = {lfsr_reg[0], lfsr_reg};

  // The generator reseeds while off so each run starts the same sequence.
  always_ff @(posedge aclk) begin
    if (!aresetn || !selftest) begin
      lfsr_reg <= `VST_LFSR_SEED;
    end else if (lfsr_step) begin
      lfsr_reg <= lfsr_next; // [RULE7]
    end
  end

  // Error character has priority, then pattern, then host data.
  vst_src_t src_sel;
  assign src_sel = pab_err_reg ? VST_SRC_ERROR : // [RULE6]
                   selftest ? VST_SRC_PATTERN : // [RULE9]
                   buffered ? VST_SRC_BUFFER : VST_SRC_DIRECT; // [RULE2]
  wire [9:0] next_char = (src_sel == VST_SRC_ERROR) ? `VST_ERR_CHAR :
                         (src_sel == VST_SRC_PATTERN) ? pattern_char :
                         (src_sel == VST_SRC_BUFFER) ? pab_mem[rd_ptr_reg] : char_s;

  //////////////////////////////////////////////////////////////////////////////
  // Transmit shifter and serial drivers.

  logic [9:0] shift_reg; // Serial shifter, LSB leaves first.
  logic [9:0] char_word_reg; // Last character loaded.
  logic out1_reg; // Primary driver output.
  logic out2_reg; // Secondary driver output.
  logic char_clk_reg; // Character clock pulse.
  logic [4:0] mult_reg; // Current multiplication factor.
  logic logic_on_reg; // Transmitter powered.

  // One bit leaves per aclk; a new tick reloads even if bits remain, which
  // is a limit of modelling the bit clock inside a slower system clock.
  always_ff @(posedge aclk) begin
    if (!aresetn || !logic_on) begin
      shift_reg <= 10'h000; // [RULE15]
      char_word_reg <= 10'h000;
    end else if (char_tick) begin
      shift_reg <= next_char; // [RULE18]
      char_word_reg <= next_char;
    end else begin
      shift_reg <= {1'b0, shift_reg[9:1]}; // [RULE18]
    end
  end

  // Drivers gate the serial bit; reset leaves both off through the control reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out1_reg <= 1'b0; // [RULE16]
      out2_reg <= 1'b0; // [RULE16]
      char_clk_reg <= 1'b0;
      mult_reg <= `VST_MULT_FULL;
      logic_on_reg <= 1'b0;
    end else begin
      out1_reg <= drv_en[0] & shift_reg[0]; // [RULE14]
      out2_reg <= drv_en[1] & shift_reg[0]; // [RULE14]
      char_clk_reg <= char_tick; // [RULE11]
      mult_reg <= rate_sel ? `VST_MULT_HALF : `VST_MULT_FULL; // [RULE10]
      logic_on_reg <= logic_on; // [RULE15]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic awready_reg; // Low once an address is held.
  logic wready_reg; // Low once data is held.
  logic bvalid_reg; // Write response pending.
  logic [1:0] bresp_reg; // Write response code.
  logic [4:0] aw_addr_reg; // Held write address.
  logic [31:0] wdata_reg; // Held write data.
  logic wstrb0_reg; // Held lane 0 strobe; every field lives in lane 0.
  logic arready_reg; // Low while a read answer waits.
  logic rvalid_reg; // Read data valid.
  logic [31:0] rdata_reg; // Read data.
  logic [1:0] rresp_reg; // Read response code.

  // The write runs once both halves are held and no response is pending.
  wire wr_go = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire wr_hit_ctrl = aw_addr_reg == `VST_ADDR_CTRL;
  wire wr_hit_en = aw_addr_reg == `VST_ADDR_INT_EN;
  wire wr_hit_clr = aw_addr_reg == `VST_ADDR_INT_CLR;
  wire wr_hit_ro = (aw_addr_reg == `VST_ADDR_STATUS) | (aw_addr_reg == `VST_ADDR_INT_STAT);
  wire wr_mapped = wr_hit_ctrl | wr_hit_en | wr_hit_clr | wr_hit_ro;
  wire wr_ctrl = wr_go & wr_hit_ctrl & wstrb0_reg;
  wire wr_en = wr_go & wr_hit_en & wstrb0_reg;
  wire wr_clr = wr_go & wr_hit_clr & wstrb0_reg;
  assign init_pulse = wr_ctrl & ~wdata_reg[`VST_CTRL_PAINIT]; // [RULE5]

  // Read decode and the status word, which shows the block's own state.
  wire [31:0] status_word = {24'h000000, rate_sel, 4'(occ_reg), cfg_invalid, logic_on_reg, pab_err_reg};
  wire rd_hit_ctrl = araddr == `VST_ADDR_CTRL;
  wire rd_hit_stat = araddr == `VST_ADDR_STATUS;
  wire rd_hit_int = araddr == `VST_ADDR_INT_STAT;
  wire rd_hit_en = araddr == `VST_ADDR_INT_EN;
  wire rd_hit_clr = araddr == `VST_ADDR_INT_CLR;
  wire rd_mapped = rd_hit_ctrl | rd_hit_stat | rd_hit_int | rd_hit_en | rd_hit_clr;
  wire [31:0] rd_word = rd_hit_ctrl ? {24'h000000, ctrl_reg} :
                        rd_hit_stat ? status_word :
                        rd_hit_int ? {29'h00000000, int_stat_reg} :
                        rd_hit_en ? {29'h00000000, int_en_reg} : 32'h00000000;

  // Write channels: each ready drops on its own handshake, back up after B.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `VST_RESP_OKAY;
      aw_addr_reg <= 5'h00;
      wdata_reg <= 32'h00000000;
      wstrb0_reg <= 1'b0;
    end else begin
      if (awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wdata_reg <= wdata;
        wstrb0_reg <= wstrb[0];
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? `VST_RESP_OKAY : `VST_RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // Read channel answers in the cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `VST_RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_mapped ? `VST_RESP_OKAY : `VST_RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Control latches; reset turns off self-test and both drivers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `VST_CTRL_RESET; // [RULE8] [RULE16]
      int_en_reg <= {`VST_INT_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata_reg[7:0]; // [RULE14]
      end
      if (wr_en) begin
        int_en_reg <= wdata_reg[`VST_INT_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  logic cfg_invalid_d_reg; // Previous invalid-configuration level.
  wire [`VST_INT_W-1:0] int_events = {cfg_invalid & ~cfg_invalid_d_reg, pattern_wrap, pab_err_set & ~pab_err_reg};
  wire [`VST_INT_W-1:0] int_clear = wr_clr ? wdata_reg[`VST_INT_W-1:0] : {`VST_INT_W{1'b0}};
  logic irq_reg; // Interrupt output.

  // A new event in the clearing cycle survives: set wins over clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_reg <= {`VST_INT_W{1'b0}};
      cfg_invalid_d_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      int_stat_reg <= int_events | (int_stat_reg & ~int_clear);
      cfg_invalid_d_reg <= cfg_invalid;
      irq_reg <= |(int_stat_reg & int_en_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output connections, all from flip-flops.

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign tx_serial_out1 = out1_reg;
  assign tx_serial_out2 = out2_reg;
  assign tx_char_clock_out = char_clk_reg;
  assign tx_phase_error = pab_err_reg; // [RULE4]
  assign tx_char_word = char_word_reg;
  assign tx_bit_mult = mult_reg;
  assign tx_logic_on = logic_on_reg;
  assign irq = irq_reg;

endmodule // vst_tx_path

// ===== core/vst_cfg.svh
`ifndef VST_CFG_SVH
`define VST_CFG_SVH

// Register byte addresses on the AXI4-Lite slave.
`define VST_ADDR_CTRL 5'h00
`define VST_ADDR_STATUS 5'h04
`define VST_ADDR_INT_STAT 5'h08
`define VST_ADDR_INT_EN 5'h0c
`define VST_ADDR_INT_CLR 5'h10

// Control register field positions.
`define VST_CTRL_CAPSEL 0
`define VST_CTRL_RATE 1
`define VST_CTRL_BAND_LO 2
`define VST_CTRL_BAND_HI 3
`define VST_CTRL_SELFTEST 4
`define VST_CTRL_PAINIT 5
`define VST_CTRL_DRV_LO 6
`define VST_CTRL_DRV_HI 7

// Control reset value: drivers off, self-test off, init latch high.
`define VST_CTRL_RESET 8'h20

// Interrupt status layout.
`define VST_INT_W 3
`define VST_INT_PHASE_ERR 0
`define VST_INT_PATTERN_WRAP 1
`define VST_INT_CFG_INVALID 2

// Fixed characters and pattern generator constants.
`define VST_ERR_CHAR 10'h278
`define VST_LFSR_SEED 9'h1ff
`define VST_LFSR_TAP 4

// Reference multiplication factors.
`define VST_MULT_FULL 5'h0a
`define VST_MULT_HALF 5'h14

// AXI response codes.
`define VST_RESP_OKAY 2'h0
`define VST_RESP_SLVERR 2'h2

`endif

// ===== core/vst_pkg.sv
package vst_pkg;

  // Serial rate band chosen by the three-level speed select.
  typedef enum logic [1:0] {
    VST_BAND_LOW = 2'h0,
    VST_BAND_MID = 2'h1,
    VST_BAND_HIGH = 2'h2,
    VST_BAND_RSVD = 2'h3
  } vst_band_t;

  // Source of the character loaded into the shifter.
  typedef enum logic [3:0] {
    VST_SRC_DIRECT = 4'b0001,
    VST_SRC_BUFFER = 4'b0010,
    VST_SRC_PATTERN = 4'b0100,
    VST_SRC_ERROR = 4'b1000
  } vst_src_t;

endpackage

// ===== core/vst_sync.sv
`timescale 1ns/100ps

// Two-stage synchroniser for signals arriving from outside the aclk domain.
module vst_sync #(
  parameter int W = 1
) (
  // Clock and synchronous reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous input and its synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg; // First stage, read only by the second stage.
  logic [W-1:0] sync_reg; // Second stage, safe for logic to use.

  // Both stages run every edge; reset clears them to a known level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule // vst_sync

// ===== verif/vst_tx_path_checker.sv
`timescale 1ns/100ps
`include "vst_cfg.svh"
////////////////////////////////////////////////////////////////
// Watches the bus handshakes and the transmit outputs of the top module.
module vst_tx_path_checker (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic awready,
  // Transmit outputs.
  input wire logic tx_serial_out1,
  input wire logic tx_serial_out2,
  input wire logic tx_char_clock_out,
  input wire logic tx_phase_error,
  input wire logic [9:0] tx_char_word,
  input wire logic [4:0] tx_bit_mult,
  input wire logic tx_logic_on
);
  // All checks live in the one clock domain.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped early");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("write response dropped early");
  aw_block_a: assert property (bvalid |-> !awready) else $error("write taken while response pending");
  ar_block_a: assert property (rvalid |-> !arready) else $error("read taken while data pending");
  rd_answer_a: assert property (arvalid && arready |=> rvalid) else $error("read data late");
  tick_pulse_a: assert property (tx_char_clock_out |=> !tx_char_clock_out) else $error("tick too long");
  mult_value_a: assert property (tx_bit_mult == `VST_MULT_FULL || tx_bit_mult == `VST_MULT_HALF)
    else $error("bad multiplier");
  // A tick well inside an error spell must carry the fixed error character.
  err_char_a: assert property (tx_phase_error && $past(tx_phase_error, 10) && tx_char_clock_out
    |-> tx_char_word == `VST_ERR_CHAR) else $error("error character missing");
  quiet_off_a: assert property (!tx_logic_on && !$past(tx_logic_on) |-> !tx_serial_out1 && !tx_serial_out2)
    else $error("output active while powered down");
  reset_off_a: assert property ($rose(aresetn) |-> !tx_serial_out1 && !tx_serial_out2 && !tx_logic_on)
    else $error("driver on after reset");
endmodule // vst_tx_path_checker

bind vst_tx_path vst_tx_path_checker i_chk (.aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .bvalid(bvalid), .bready(bready), .awready(awready),
  .tx_serial_out1(tx_serial_out1), .tx_serial_out2(tx_serial_out2), .tx_char_clock_out(tx_char_clock_out),
  .tx_phase_error(tx_phase_error), .tx_char_word(tx_char_word), .tx_bit_mult(tx_bit_mult),
  .tx_logic_on(tx_logic_on));

// ===== verif/vst_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// Host side of the parallel link: clocks stand still outside frames.
module vst_host_model (
  // Frame and fault controls from the bench.
  input wire logic run,
  input wire logic slip,
  input wire logic [9:0] char_val,
  // Link pins.
  output logic ref_clk,
  output logic host_clk,
  output logic [9:0] char_out
);
  // Reference clock of 400 ns, offset so its edges never meet aclk edges.
  initial begin
    ref_clk = 1'b0;
    #13;
    forever begin
      #200;
      if (run) begin
        ref_clk = ~ref_clk;
      end
    end
  end
  // Host clock locked to the reference; slip runs it fast to break the drift limit.
  initial begin
    host_clk = 1'b0;
    #13;
    forever begin
      #(slip ? 150 : 200);
      if (run) begin
        host_clk = ~host_clk;
      end
    end
  end
  // Data moves mid-period so it is steady around every rising capture edge.
  initial char_out = 10'h000;
  always @(negedge ref_clk) char_out <= char_val;
endmodule // vst_host_model

// ===== verif/tb_vst_tx_path.sv
`timescale 1ns/100ps
`include "vst_cfg.svh"
////////////////////////////////////////////////////////////////
// Self-checking bench for the transmit path.
module tb_vst_tx_path;
  // Bus and link signals.
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run, slip, refc, hostc;
  logic awready, wready, bvalid, arready, rvalid, s1, s2, cko, perr, lon, irq;
  logic [4:0] awaddr, araddr, mult;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [9:0] word, char_val, chr;
  logic [9:0] w [0:519];
  int n_fail = 0, n_checks = 0, seen1, seen2;
  logic [31:0] seed = 32'h0000d06c;
  vst_host_model i_host (.run(run), .slip(slip), .char_val(char_val), .ref_clk(refc), .host_clk(hostc),
    .char_out(chr));
  vst_tx_path #(.PAB_DEPTH(4)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .tx_char_in(chr), .host_tx_clock(hostc),
    .tx_reference_clock(refc), .tx_serial_out1(s1), .tx_serial_out2(s2), .tx_char_clock_out(cko),
    .tx_phase_error(perr), .tx_char_word(word), .tx_bit_mult(mult), .tx_logic_on(lon), .irq(irq));
  ////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Fixed-seed xorshift keeps every run the same.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Control byte: drivers, init latch, self-test, mid band, rate, capture select.
  function automatic logic [7:0] cw(input logic [1:0] drv, input logic st, input logic pai, input logic rt,
    input logic sel);
    return {drv, pai, st, 2'h1, rt, sel};
  endfunction
  function automatic logic [4:0] exp_mult(input logic rt);
    return rt ? `VST_MULT_HALF : `VST_MULT_FULL;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write; each channel is released at the edge it is taken.
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog sized well above the longest pass through the scenarios.
  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, run, slip} = 7'h00;
    {awaddr, araddr, char_val} = '0;
    wdata = 32'h0;
    wstrb = 4'h1;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`VST_ADDR_CTRL);
    chk(d, `VST_CTRL_RESET);
    chk({s1, s2, lon}, 3'h0);
    rd(5'h14);
    chk({r, d[7:0]}, {`VST_RESP_SLVERR, 8'h00});
    wr(5'h1c, 8'hff);
    chk(r, `VST_RESP_SLVERR);
    run <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(`VST_ADDR_CTRL, cw(2'h3, 1'b0, 1'b1, k[0], 1'b1));
      rd(`VST_ADDR_STATUS);
      chk({mult, d[7]}, {exp_mult(k[0]), k[0]});
    end
    // Random characters through the buffered path, then the bypass path.
    for (int k = 0; k < 6; k++) begin
      if (k % 3 == 0) begin
        wr(`VST_ADDR_CTRL, cw(2'h3, 1'b0, 1'b0, 1'b0, k > 2));
        wr(`VST_ADDR_CTRL, cw(2'h3, 1'b0, 1'b1, 1'b0, k > 2));
      end
      seed = xs(seed);
      char_val <= seed[9:0];
      repeat (64) @(posedge aclk);
      chk(word, seed[9:0]);
    end
    // Every driver combination; all-off must power the transmitter down.
    char_val <= 10'h155;
    for (int m = 3; m >= 0; m--) begin
      wr(`VST_ADDR_CTRL, cw(m[1:0], 1'b0, 1'b1, 1'b0, 1'b1));
      {seen1, seen2} = 0;
      repeat (64) begin
        @(posedge aclk);
        seen1 += (s1 === 1'b1);
        seen2 += (s2 === 1'b1);
      end
      chk({seen1 > 0, seen2 > 0}, {m[0], m[1]});
      chk(lon, m != 0);
    end
    // Host clock runs fast until the buffer slips.
    wr(`VST_ADDR_CTRL, cw(2'h3, 1'b0, 1'b0, 1'b0, 1'b0));
    wr(`VST_ADDR_CTRL, cw(2'h3, 1'b0, 1'b1, 1'b0, 1'b0));
    wr(`VST_ADDR_INT_EN, 8'h07);
    slip <= 1'b1;
    repeat (400) @(posedge aclk);
    slip <= 1'b0;
    repeat (80) @(posedge aclk);
    chk({perr, irq, word}, {2'h3, `VST_ERR_CHAR});
    wr(`VST_ADDR_INT_EN, 8'h00);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    wr(`VST_ADDR_INT_CLR, 8'h07);
    wr(`VST_ADDR_INT_EN, 8'h07);
    repeat (2) @(posedge aclk);
    chk({perr, irq}, 2'h2);
    wr(`VST_ADDR_CTRL, cw(2'h3, 1'b0, 1'b0, 1'b0, 1'b0));
    wr(`VST_ADDR_CTRL, cw(2'h3, 1'b0, 1'b1, 1'b0, 1'b0));
    repeat (20) @(posedge aclk);
    chk(perr, 1'b0);
    // Self-test with the data pins churning; the sequence must repeat after 511.
    wr(`VST_ADDR_CTRL, cw(2'h3, 1'b1, 1'b1, 1'b0, 1'b1));
    for (int i = 0; i < 520; i++) begin
      do @(posedge aclk); while (cko !== 1'b1);
      w[i] = word;
      seed = xs(seed);
      char_val <= seed[9:0];
    end
    for (int i = 2; i < 9; i++) begin
      chk(w[i + 511], w[i]);
      chk(w[i + 1][8:0], {w[i][7:0], w[i][8] ^ w[i][`VST_LFSR_TAP]});
    end
    rd(`VST_ADDR_INT_STAT);
    chk(d[`VST_INT_PATTERN_WRAP], 1'b1);
    // The reserved band code must be reported as an invalid setting.
    wr(`VST_ADDR_CTRL, 8'h0c);
    rd(`VST_ADDR_STATUS);
    chk(d[2], 1'b1);
    close_out();
  end
endmodule // tb_vst_tx_path
